//--- bench/pfd_timer_model.sv
// Counter flow model that feeds phase strobes to the fault block
`timescale 1ns/10ps
`default_nettype none
module pfd_timer_model #(
   parameter int LEN = 8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pfd_pkg::pfd_ctrl_s ctrl_q,
   output var pfd_pkg::pfd_timer_s timer
);
   import pfd_pkg::*;
   int cnt_q;
   pfd_phase_e phase_q;
   logic last;

   // Last cycle of a phase, never while held or reloading
   assign last = (cnt_q == LEN - 1) && !ctrl_q.halt && !ctrl_q.jump;
   always_comb begin
      timer.phase = phase_q;
      timer.phase_end = last;
      timer.cycle_end = last && (phase_q == PFD_PH_OTB);
   end

   // Halt holds, jump reloads, stretch inserts one cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 0;
         phase_q <= PFD_PH_DTA;
      end else if (ctrl_q.jump) begin
         cnt_q <= 0;
         phase_q <= ctrl_q.jump_phase;
      end else if (ctrl_q.halt || ctrl_q.stretch) begin
         cnt_q <= cnt_q;
      end else if (last) begin
         cnt_q <= 0;
         phase_q <= pfd_phase_e'(phase_q + 2'h1);
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the fault input and dither block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pfd_pkg::*;
   localparam int DW = 8;
   localparam int LEN = 8;
   logic ref_clk;
   logic reset_n;
   logic flt_a;
   logic flt_b;
   logic [3:0] mode_a;
   logic [3:0] mode_b;
   pfd_dsel_e dsel;
   pfd_wave_e wave;
   logic [DW-1:0] step;
   logic restart;
   pfd_timer_s tmr;
   pfd_ctrl_s ctl;
   int mismatches;
   int num_checks;
   int acc;
   int nj;
   logic [1:0] exp_extra;
   logic dith_on;
   int tbl [4][4] = '{'{1, 1, 0, 0}, '{1, 2, 0, 0}, '{1, 2, 1, 2}, '{0, 0, 0, 0}};
   int m35 [2] = '{3, 5};

   // Design and counter flow model
   pfd_fault_dither #(.DITHER_W(DW)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
      .fault_in_a(flt_a), .fault_in_b(flt_b), .fault_input_mode_a(mode_a),
      .fault_input_mode_b(mode_b), .dither_place_select(dsel), .waveform_mode_select(wave),
      .dither_step(step), .restart_strobe(restart), .timer(tmr), .ctrl_q(ctl));
   pfd_timer_model #(.LEN(LEN)) u_timer (.ref_clk(ref_clk), .reset_n(reset_n),
      .ctrl_q(ctl), .timer(tmr));

   // Counter clock, 100 ns
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic do_reset();
      flt_a = 1'b0;
      flt_b = 1'b0;
      restart = 1'b0;
      reset_n = 1'b0;
      cyc(5);
      reset_n = 1'b1;
      cyc(1);
   endtask

   // Wait for the first cycle of a phase
   task automatic at_start(input pfd_phase_e p);
      pfd_phase_e prev;
      int n;
      n = 0;
      prev = tmr.phase;
      cyc(1);
      while (!(tmr.phase == p && prev != p) && n < 100) begin
         prev = tmr.phase;
         cyc(1);
         n++;
      end
      if (n >= 100) begin
         mismatches++;
         $display("wrong value at %0t: phase never started", $time);
      end
   endtask

   task automatic wait_ctl(input logic jmp, input logic v);
      int n;
      n = 0;
      while ((jmp ? ctl.jump : ctl.halt) !== v && n < 5 * LEN) begin
         cyc(1);
         n++;
      end
      if (n >= 5 * LEN) begin
         mismatches++;
         $display("wrong value at %0t: control never changed", $time);
      end
   endtask

   // Dither accumulator model, one step per timer cycle
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc = 0;
         exp_extra = 2'h0;
      end else begin
         exp_extra = 2'h0;
         if (tmr.cycle_end && wave != PFD_WG_DUAL) begin
            acc = acc + int'(step);
            if (acc >= (1 << DW)) begin
               acc = acc - (1 << DW);
               exp_extra = 2'(tbl[wave][dsel]);
            end
         end
      end
   end

   // Compare dither result every cycle
   always @(negedge ref_clk) begin
      if (dith_on) begin
         chk(ctl.extra, exp_extra);
         if (wave == PFD_WG_DUAL) chk(ctl.stretch, 1'b0);
      end
   end

   // Watchdog against a hang
   initial begin
      #(100 * 40000);
      mismatches++;
      finish_test();
   end

   initial begin
      mismatches = 0;
      num_checks = 0;
      dith_on = 1'b0;
      flt_a = 1'b0;
      flt_b = 1'b0;
      restart = 1'b0;
      reset_n = 1'b0;
      mode_a = PFD_MODE_NONE;
      mode_b = PFD_MODE_NONE;
      dsel = PFD_DS_ONB;
      wave = PFD_WG_TWO;
      step = 8'h00;
      void'($urandom(32'h1fa3));
      @(negedge ref_clk);
      do_reset();
      chk(ctl, PFD_CTRL_RST);
      // No action in mode 0, modes 1 and 2 ignore B phases
      for (int m = 0; m < 3; m++) begin
         do_reset();
         mode_a = 4'(m);
         at_start(PFD_PH_DTB);
         flt_a = 1'b1;
         cyc(3);
         chk({ctl.jump, ctl.gate_a, ctl.halt}, 3'b010);
      end
      // Mode 2 fault in on-time A, then wait
      do_reset();
      at_start(PFD_PH_OTA);
      flt_a = 1'b1;
      cyc(3);
      chk({ctl.jump, ctl.jump_phase, ctl.gate_a, ctl.gate_b}, {1'b1, PFD_PH_DTB, 2'b01});
      wait_ctl(1'b0, 1'b1);
      chk({ctl.halt, tmr.phase}, {1'b1, PFD_PH_DTA});
      flt_a = 1'b0;
      wait_ctl(1'b0, 1'b0);
      cyc(1);
      chk({ctl.halt, ctl.gate_a}, 2'b01);
      // Mode 2 early release, no wait
      do_reset();
      at_start(PFD_PH_OTA);
      flt_a = 1'b1;
      cyc(2);
      flt_a = 1'b0;
      cyc(1);
      chk(ctl.jump, 1'b1);
      for (int k = 0; k < 5 * LEN; k++) begin
         cyc(1);
         chk(ctl.halt, 1'b0);
      end
      // Modes 3 and 5, repeated jumps while active
      foreach (m35[i]) begin
         do_reset();
         mode_a = 4'(m35[i]);
         at_start(PFD_PH_OTA);
         flt_a = 1'b1;
         cyc(3);
         chk({ctl.jump, ctl.jump_phase, ctl.gate_a, ctl.gate_b},
            {1'b1, PFD_PH_DTB, 1'b0, m35[i] == 3});
         nj = 0;
         for (int k = 0; k < 6 * LEN; k++) begin
            cyc(1);
            nj += int'(ctl.jump);
         end
         chk(nj >= 2, 1'b1);
         flt_a = 1'b0;
         at_start(PFD_PH_OTA);
         cyc(1);
         chk({ctl.gate_a, ctl.gate_b}, 2'b11);
      end
      // Mode 4 on each input
      for (int i = 0; i < 2; i++) begin
         do_reset();
         mode_a = (i == 0) ? PFD_MODE_4 : PFD_MODE_NONE;
         mode_b = (i == 1) ? PFD_MODE_4 : PFD_MODE_NONE;
         flt_a = (i == 0);
         flt_b = (i == 1);
         cyc(3);
         for (int k = 0; k < 3 * LEN; k++) begin
            chk({ctl.gate_a, ctl.gate_b, ctl.halt, ctl.jump}, 4'b0000);
            cyc(1);
         end
         flt_a = 1'b0;
         flt_b = 1'b0;
         cyc(3);
         chk({ctl.gate_a, ctl.gate_b}, 2'b11);
      end
      // Mode 6 on B halts, jumps on release
      do_reset();
      mode_b = PFD_MODE_6;
      at_start(PFD_PH_OTB);
      flt_b = 1'b1;
      cyc(3);
      chk({ctl.halt, ctl.gate_a, ctl.gate_b}, 3'b100);
      cyc(LEN);
      chk(ctl.halt, 1'b1);
      flt_b = 1'b0;
      wait_ctl(1'b1, 1'b1);
      chk({ctl.jump, ctl.jump_phase}, {1'b1, PFD_PH_DTA});
      // Mode 7 on B, refused and accepted restart
      do_reset();
      mode_b = PFD_MODE_7;
      at_start(PFD_PH_OTA);
      flt_b = 1'b1;
      cyc(3);
      chk({ctl.halt, ctl.gate_a, ctl.gate_b}, 3'b100);
      restart = 1'b1;
      cyc(1);
      restart = 1'b0;
      chk({ctl.halt, ctl.jump}, 2'b10);
      flt_b = 1'b0;
      cyc(4);
      chk(ctl.halt, 1'b1);
      restart = 1'b1;
      cyc(1);
      restart = 1'b0;
      chk({ctl.jump, ctl.jump_phase, ctl.halt, ctl.gate_a, ctl.gate_b},
         {1'b1, PFD_PH_DTA, 3'b000});
      cyc(1);
      chk({ctl.halt, ctl.gate_a, ctl.gate_b}, 3'b011);
      // Mode 8 on B, dead time ignored, on-time jumps
      do_reset();
      mode_b = PFD_MODE_8;
      at_start(PFD_PH_DTB);
      flt_b = 1'b1;
      cyc(3);
      chk({ctl.jump, ctl.gate_b}, 2'b01);
      flt_b = 1'b0;
      at_start(PFD_PH_OTB);
      flt_b = 1'b1;
      cyc(3);
      chk({ctl.jump, ctl.jump_phase, ctl.gate_b}, {1'b1, PFD_PH_DTA, 1'b0});
      // Modes 9 and 10 blank the rest of on-time A
      for (int m = 9; m < 11; m++) begin
         do_reset();
         mode_b = PFD_MODE_NONE;
         mode_a = 4'(m);
         at_start(PFD_PH_OTA);
         flt_a = 1'b1;
         cyc(2);
         flt_a = 1'b0;
         cyc(1);
         chk({ctl.gate_a, ctl.gate_b, ctl.jump, ctl.halt}, 4'b0100);
         cyc(3);
         chk({ctl.gate_a, tmr.phase}, {1'b0, PFD_PH_OTA});
         at_start(PFD_PH_DTB);
         cyc(2);
         chk(ctl.gate_a, 1'b1);
      end
      // Dither for every ramp mode and placement
      mode_a = PFD_MODE_NONE;
      dith_on = 1'b1;
      for (int w = 0; w < 4; w++) begin
         for (int s = 0; s < 4; s++) begin
            wave = pfd_wave_e'(w);
            dsel = pfd_dsel_e'(s);
            step = 8'h80 | 8'($urandom);
            do_reset();
            cyc(12 * 4 * LEN);
         end
      end
      dith_on = 1'b0;
      finish_test();
   end
endmodule
`default_nettype wire

//--- hw/pfd_fault_dither.sv
// Fault input handling and dither control for the control timer
`timescale 1ns/10ps
`default_nettype none
module pfd_fault_dither #(
   parameter int unsigned DITHER_W = pfd_pkg::PFD_DITHER_W
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic fault_in_a,
   input wire logic fault_in_b,
   input wire logic [3:0] fault_input_mode_a,
   input wire logic [3:0] fault_input_mode_b,
   input wire pfd_pkg::pfd_dsel_e dither_place_select,
   input wire pfd_pkg::pfd_wave_e waveform_mode_select,
   input wire logic [DITHER_W-1:0] dither_step,
   input wire logic restart_strobe,
   input wire pfd_pkg::pfd_timer_s timer,
   output var pfd_pkg::pfd_ctrl_s ctrl_q
);
   import pfd_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] prev_q;

   // Two flops, then a third for edge detection
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= PFD_SYNC_RST;
         sync2_q <= PFD_SYNC_RST;
         prev_q <= PFD_SYNC_RST;
      end else begin
         sync1_q <= {fault_in_b, fault_in_a};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Levels, edges and phase helpers
   wire logic [1:0] flt = sync2_q;
   wire logic [1:0] rise = sync2_q & ~prev_q;
   wire logic side_a = (timer.phase == PFD_PH_DTA) || (timer.phase == PFD_PH_OTA);
   wire logic on_time = (timer.phase == PFD_PH_OTA) || (timer.phase == PFD_PH_OTB);
   wire pfd_phase_e nxt_dt = side_a ? PFD_PH_DTB : PFD_PH_DTA;

   // ****************************************
   // Common modes 4 to 7, either input
   // ****************************************
   wire logic a_com = (fault_input_mode_a >= PFD_MODE_4) && (fault_input_mode_a <= PFD_MODE_7);
   wire logic b_com = (fault_input_mode_b >= PFD_MODE_4) && (fault_input_mode_b <= PFD_MODE_7);
   wire logic [3:0] cm_mode = a_com ? fault_input_mode_a : fault_input_mode_b;
   wire logic cm_fault = (flt[0] && a_com) || (flt[1] && b_com);

   pfd_cmst_e cm_st_q;
   pfd_cmst_e cm_st_d;
   pfd_phase_e cm_tgt_q;
   pfd_phase_e cm_tgt_d;
   logic cm_off;
   logic cm_halt;
   logic cm_jump;
   pfd_phase_e cm_jtgt;

   // Shared fault sequencer
   always_comb begin
      cm_st_d = cm_st_q;
      cm_tgt_d = cm_tgt_q;
      cm_off = 1'b0;
      cm_halt = 1'b0;
      cm_jump = 1'b0;
      cm_jtgt = cm_tgt_q;
      unique case (cm_st_q)
         PFD_CM_IDLE: begin
            if (cm_fault) begin
               cm_off = 1'b1;
               if (cm_mode == PFD_MODE_5) begin
                  cm_st_d = PFD_CM_DEAD;
                  if (on_time) begin
                     cm_jump = 1'b1;
                     cm_jtgt = nxt_dt;
                  end
               end else if (cm_mode == PFD_MODE_6) begin
                  cm_st_d = PFD_CM_HOLD;
                  cm_halt = 1'b1;
                  cm_tgt_d = nxt_dt;
               end else if (cm_mode == PFD_MODE_7) begin
                  cm_st_d = PFD_CM_LOCK;
                  cm_halt = 1'b1;
               end
            end
         end
         PFD_CM_DEAD: begin
            cm_off = cm_fault;
            if (timer.phase_end && !on_time) begin
               if (cm_fault) begin
                  cm_jump = 1'b1;
                  cm_jtgt = nxt_dt;
               end else begin
                  cm_st_d = PFD_CM_IDLE;
               end
            end
         end
         PFD_CM_HOLD: begin
            cm_off = 1'b1;
            cm_halt = cm_fault;
            if (!cm_fault) begin
               cm_jump = 1'b1;
               cm_st_d = PFD_CM_IDLE;
            end
         end
         PFD_CM_LOCK: begin
            cm_off = 1'b1;
            cm_halt = 1'b1;
            if (restart_strobe && !cm_fault) begin
               cm_halt = 1'b0;
               cm_jump = 1'b1;
               cm_jtgt = PFD_PH_DTA;
               cm_st_d = PFD_CM_IDLE;
            end
         end
      endcase
   end

   // Shared sequencer state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cm_st_q <= PFD_CM_IDLE;
         cm_tgt_q <= PFD_PH_DTA;
      end else begin
         cm_st_q <= cm_st_d;
         cm_tgt_q <= cm_tgt_d;
      end
   end

   // ****************************************
   // Per-input modes 1 to 3 and 8 to 10
   // ****************************************
   logic [1:0] ch_off;
   logic [1:0] ch_halt;
   logic [1:0] ch_jump;
   pfd_phase_e [1:0] ch_tgt;

   for (genvar i = 0; i < 2; i++) begin : g_ch
      localparam pfd_phase_e OWN_DT = (i == 0) ? PFD_PH_DTA : PFD_PH_DTB;
      localparam pfd_phase_e OWN_OT = (i == 0) ? PFD_PH_OTA : PFD_PH_OTB;
      localparam pfd_phase_e OPP_DT = (i == 0) ? PFD_PH_DTB : PFD_PH_DTA;
      localparam pfd_phase_e OPP_OT = (i == 0) ? PFD_PH_OTB : PFD_PH_OTA;
      wire logic [3:0] md = (i == 0) ? fault_input_mode_a : fault_input_mode_b;
      wire logic f = flt[i];
      wire logic r = rise[i];
      wire logic in_own = (timer.phase == OWN_DT) || (timer.phase == OWN_OT);
      pfd_chst_e st_q;
      pfd_chst_e st_d;
      logic off;
      logic hlt;
      logic jmp;

      // Channel sequencer
      always_comb begin
         st_d = st_q;
         off = 1'b0;
         hlt = 1'b0;
         jmp = 1'b0;
         unique case (st_q)
            PFD_CH_IDLE: begin
               unique case (md)
                  PFD_MODE_1: begin
                     if (f && in_own) begin
                        off = 1'b1;
                        jmp = 1'b1;
                        st_d = PFD_CH_WAIT;
                     end
                  end
                  PFD_MODE_2, PFD_MODE_3: begin
                     if (f && in_own) begin
                        off = 1'b1;
                        jmp = 1'b1;
                        st_d = PFD_CH_EXEC;
                     end
                  end
                  PFD_MODE_8: begin
                     if (r && timer.phase == OWN_OT) begin
                        off = 1'b1;
                        jmp = 1'b1;
                     end
                  end
                  PFD_MODE_9: begin
                     if (r && timer.phase == OWN_OT) begin
                        off = 1'b1;
                        st_d = PFD_CH_BLOCK;
                     end
                  end
                  PFD_MODE_10: begin
                     if (f) begin
                        off = 1'b1;
                        st_d = PFD_CH_BLOCK;
                     end
                  end
                  default: begin
                     off = 1'b0;
                  end
               endcase
            end
            PFD_CH_EXEC: begin
               off = 1'b1;
               if (timer.phase_end && timer.phase == OPP_OT) begin
                  if (md == PFD_MODE_3 && f) begin
                     jmp = 1'b1;
                  end else if (md == PFD_MODE_2 && f) begin
                     hlt = 1'b1;
                     st_d = PFD_CH_WAIT;
                  end else begin
                     st_d = PFD_CH_IDLE;
                  end
               end
            end
            PFD_CH_WAIT: begin
               off = 1'b1;
               hlt = f;
               if (!f) begin
                  st_d = PFD_CH_IDLE;
               end
            end
            PFD_CH_BLOCK: begin
               off = 1'b1;
               if (!(md == PFD_MODE_10 && f) && timer.phase != OWN_OT) begin
                  st_d = PFD_CH_IDLE;
               end
            end
         endcase
      end

      // Channel state
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            st_q <= PFD_CH_IDLE;
         end else begin
            st_q <= st_d;
         end
      end

      // Gather channel requests
      assign ch_off[i] = off;
      assign ch_halt[i] = hlt;
      assign ch_jump[i] = jmp;
      assign ch_tgt[i] = OPP_DT;
   end

   // ****************************************
   // Dither
   // ****************************************
   logic [DITHER_W-1:0] acc_q;
   logic pend_q;

   // Cycles added per overflow, by ramp mode and placement
   function automatic logic [1:0] cyc_add(input pfd_wave_e wg, input pfd_dsel_e ds);
      logic [1:0] n;
      n = 2'h0;
      unique case (wg)
         PFD_WG_ONE: n = (ds == PFD_DS_ONB || ds == PFD_DS_ONAB) ? 2'h1 : 2'h0;
         PFD_WG_TWO: n = (ds == PFD_DS_ONB) ? 2'h1 : (ds == PFD_DS_ONAB) ? 2'h2 : 2'h0;
         PFD_WG_FOUR: n = (ds == PFD_DS_ONB || ds == PFD_DS_DTB) ? 2'h1 : 2'h2;
         PFD_WG_DUAL: n = 2'h0;
      endcase
      return n;
   endfunction

   // Overflow, placement and pending request
   wire logic dual = waveform_mode_select == PFD_WG_DUAL;
   wire logic [DITHER_W:0] acc_sum = {1'b0, acc_q} + {1'b0, dither_step};
   wire logic ovf = timer.cycle_end && acc_sum[DITHER_W] && !dual;
   wire logic place_hit =
      (dither_place_select == PFD_DS_ONB && timer.phase == PFD_PH_OTB) ||
      (dither_place_select == PFD_DS_ONAB && on_time) ||
      (dither_place_select == PFD_DS_DTB && timer.phase == PFD_PH_DTB) ||
      (dither_place_select == PFD_DS_DTAB && !on_time);
   wire logic stretch_now = pend_q && timer.phase_end && place_hit && !dual;
   wire logic pend_clr = (stretch_now && !side_a) || dual;

   // Accumulator and pending flag, overflow wins over clear
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= '0;
         pend_q <= 1'b0;
      end else begin
         if (timer.cycle_end && !dual) begin
            acc_q <= acc_sum[DITHER_W-1:0];
         end
         pend_q <= ovf || (pend_q && !pend_clr);
      end
   end

   // ****************************************
   // Output register
   // ****************************************
   wire logic any_jump = cm_jump || (|ch_jump);
   wire pfd_phase_e jump_tgt = cm_jump ? cm_jtgt : ch_jump[0] ? ch_tgt[0] : ch_tgt[1];

   // Every output comes from this flop
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= PFD_CTRL_RST;
      end else begin
         ctrl_q.gate_a <= !(cm_off || ch_off[0]);
         ctrl_q.gate_b <= !(cm_off || ch_off[1]);
         ctrl_q.halt <= cm_halt || (|ch_halt);
         ctrl_q.jump <= any_jump;
         ctrl_q.jump_phase <= jump_tgt;
         ctrl_q.stretch <= stretch_now;
         ctrl_q.extra <= ovf ? cyc_add(waveform_mode_select, dither_place_select) : 2'h0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   wire logic quiet_cm = (cm_st_q == PFD_CM_IDLE) && !cm_fault;

   sequence s_locked;
      cm_st_q == PFD_CM_LOCK;
   endsequence

   property p_mode4_off;
      (cm_fault && cm_mode == PFD_MODE_4) |=> (!ctrl_q.gate_a && !ctrl_q.gate_b && !ctrl_q.halt);
   endproperty
   a_mode4_off: assert property (p_mode4_off) else $error("mode 4 left an output on");

   property p_lock_halt;
      s_locked ##0 !restart_strobe |=> ctrl_q.halt && !ctrl_q.gate_a;
   endproperty
   a_lock_halt: assert property (p_lock_halt) else $error("mode 7 lock not halted");

   property p_restart_ok;
      s_locked ##0 (restart_strobe && !cm_fault) |=>
         ctrl_q.jump && ctrl_q.jump_phase == PFD_PH_DTA && !ctrl_q.halt;
   endproperty
   a_restart_ok: assert property (p_restart_ok) else $error("restart not at dead time A");

   property p_restart_refused;
      s_locked ##0 (restart_strobe && cm_fault) |=> !ctrl_q.jump ##1 ctrl_q.halt;
   endproperty
   a_restart_refused: assert property (p_restart_refused) else $error("restart taken in fault");

   property p_mode2_jump;
      (quiet_cm && g_ch[0].st_q == PFD_CH_IDLE && fault_input_mode_a == PFD_MODE_2 && flt[0]
         && side_a) |=> ctrl_q.jump && ctrl_q.jump_phase == PFD_PH_DTB && !ctrl_q.gate_a;
   endproperty
   a_mode2_jump: assert property (p_mode2_jump) else $error("mode 2 did not jump");

   property p_mode8_jump;
      (quiet_cm && fault_input_mode_b == PFD_MODE_8 && rise[1] && timer.phase == PFD_PH_OTB
         && !ch_jump[0]) |=> ctrl_q.jump && ctrl_q.jump_phase == PFD_PH_DTA;
   endproperty
   a_mode8_jump: assert property (p_mode8_jump) else $error("mode 8 wrong jump");

   property p_mode9_blank;
      (quiet_cm && g_ch[0].st_q == PFD_CH_IDLE && fault_input_mode_a == PFD_MODE_9 && rise[0]
         && timer.phase == PFD_PH_OTA) ##1 (timer.phase == PFD_PH_OTA) |=>
         !ctrl_q.gate_a && !ctrl_q.jump;
   endproperty
   a_mode9_blank: assert property (p_mode9_blank) else $error("mode 9 on-time not blanked");

   property p_mode10_level;
      (flt[0] && fault_input_mode_a == PFD_MODE_10) |=> !ctrl_q.gate_a;
   endproperty
   a_mode10_level: assert property (p_mode10_level) else $error("mode 10 output on");

   property p_dual_none;
      dual |=> !ctrl_q.stretch && ctrl_q.extra == 2'h0;
   endproperty
   a_dual_none: assert property (p_dual_none) else $error("dither active in dual slope");

   property p_four_ramp_add;
      (ovf && waveform_mode_select == PFD_WG_FOUR && dither_place_select == PFD_DS_DTAB)
         |=> ctrl_q.extra == 2'h2;
   endproperty
   a_four_ramp_add: assert property (p_four_ramp_add) else $error("wrong dither addition");

   property p_pend_stretch;
      (pend_q && timer.phase_end && place_hit && !dual) |=> ctrl_q.stretch;
   endproperty
   a_pend_stretch: assert property (p_pend_stretch) else $error("overflow not applied");

endmodule
`default_nettype wire

//--- include/pfd_pkg.sv
// Shared types and constants for the fault input and dither block
// How it works
// - Mode 2: cut, run opposite phases, wait
// - Mode 2: early release runs phases, no wait
// - Mode 2: input acts in own phases only
// - Mode 3: repeat opposite phases while fault active
// - Mode 3: release finishes phase, then normal flow
// - Mode 4: both outputs off, counter untouched
// - Mode 5: on-time jumps, dead-time skips on-time
// - Mode 5: dead times alternate until release
// - Mode 6: like mode 5, counter halts
// - Mode 7: halt outputs and counter until restart
// - Mode 7: restart refused if fault, resumes DTA
// - Mode 8: edge in on-time jumps opposite dead
// - Mode 9: edge blanks rest of on-time
// - Mode 10: off while active, rest of on-time
// - Modes 4 to 7: both inputs act alike
// - Dither accumulates error, overflow adds up to two cycles
// - Dither placement chosen by select setting
// - No dither in dual slope mode
// - Added cycles follow ramp mode table
// - Mode field zero means no action
`default_nettype none
package pfd_pkg;

   // ****************************************
   // Timer phases and modes
   // ****************************************
   typedef enum logic [1:0] {PFD_PH_DTA, PFD_PH_OTA, PFD_PH_DTB, PFD_PH_OTB} pfd_phase_e;
   typedef enum logic [1:0] {PFD_DS_ONB, PFD_DS_ONAB, PFD_DS_DTB, PFD_DS_DTAB} pfd_dsel_e;
   typedef enum logic [1:0] {PFD_WG_ONE, PFD_WG_TWO, PFD_WG_FOUR, PFD_WG_DUAL} pfd_wave_e;
   typedef enum {PFD_CH_IDLE, PFD_CH_EXEC, PFD_CH_WAIT, PFD_CH_BLOCK} pfd_chst_e;
   typedef enum {PFD_CM_IDLE, PFD_CM_DEAD, PFD_CM_HOLD, PFD_CM_LOCK} pfd_cmst_e;

   // Fault input mode codes
   localparam logic [3:0] PFD_MODE_NONE = 4'h0;
   localparam logic [3:0] PFD_MODE_1 = 4'h1;
   localparam logic [3:0] PFD_MODE_2 = 4'h2;
   localparam logic [3:0] PFD_MODE_3 = 4'h3;
   localparam logic [3:0] PFD_MODE_4 = 4'h4;
   localparam logic [3:0] PFD_MODE_5 = 4'h5;
   localparam logic [3:0] PFD_MODE_6 = 4'h6;
   localparam logic [3:0] PFD_MODE_7 = 4'h7;
   localparam logic [3:0] PFD_MODE_8 = 4'h8;
   localparam logic [3:0] PFD_MODE_9 = 4'h9;
   localparam logic [3:0] PFD_MODE_10 = 4'hA;

   // Dither accumulator default width
   localparam int unsigned PFD_DITHER_W = 8;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      pfd_phase_e phase;
      logic phase_end;
      logic cycle_end;
   } pfd_timer_s;

   typedef struct packed {
      logic gate_a;
      logic gate_b;
      logic halt;
      logic jump;
      pfd_phase_e jump_phase;
      logic stretch;
      logic [1:0] extra;
   } pfd_ctrl_s;

   // Reset values
   localparam logic [1:0] PFD_SYNC_RST = 2'h0;
   localparam logic [1:0] PFD_EXTRA_RST = 2'h0;
   localparam pfd_ctrl_s PFD_CTRL_RST = '{gate_a: 1'b1, gate_b: 1'b1, halt: 1'b0,
      jump: 1'b0, jump_phase: PFD_PH_DTA, stretch: 1'b0, extra: PFD_EXTRA_RST};

endpackage
`default_nettype wire
